// ==== ispc_consts.svh ====
// shared constants for the sensor pin control block
`ifndef ISPC_CONSTS_SVH
`define ISPC_CONSTS_SVH

// default array geometry of the pointer shift chains
`define ISPC_ROWS_DEFAULT   1024
`define ISPC_COLS_DEFAULT   1024

// pixel word width delivered by the converter
`define ISPC_PIXEL_W        10

// synchroniser depth for every controller-driven pin input
`define ISPC_SYNC_STAGES    2

// register map, byte offsets on the bus
`define ISPC_ADDR_W         4
`define ISPC_OFS_ROWPTR     4'h0
`define ISPC_OFS_COLSTAT    4'h4
`define ISPC_OFS_CTRL       4'h8
`define ISPC_OFS_PIXEL      4'hC

// control register field and reset value
`define ISPC_CTRL_FLOAT_BIT 0
`define ISPC_CTRL_RESET     1'h0

`endif

// ==== ispc_pkg.sv ====
// types shared by the sensor pin control modules
package ispc_pkg;

    // every controller-driven pin, grouped so one synchroniser covers all
    typedef struct packed {
        logic       rightInitN;    // right row pointer sync, low active
        logic       rightClk;      // right row pointer clock
        logic       leftInitN;     // left row pointer start, low active
        logic       leftClk;       // left row pointer clock
        logic       colInitN;      // column pointer sync, low active
        logic       colClk;        // column pointer clock
        logic       rowSelect;     // row select strobe
        logic       rowReset;      // row reset strobe
        logic       ptrSelLeft;    // 1 = left pointer, 0 = right pointer
        logic       colHold;       // 1 = hold, 0 = track
        logic       colCalib;      // column offset calibration
        logic       ampExtSel;     // 1 = external input, 0 = core
        logic       slowDark;      // slow dark-offset switch
        logic [3:0] gainWord;      // amplifier gain word
        logic       unityGain;     // forces unity gain
        logic       fastDark;      // fast dark-offset calibration
        logic [3:0] blackWord;     // black level DAC word
        logic       adcClk;        // conversion clock
        logic       invertBits;    // inverts the pixel word
        logic       outFloat;      // 1 = float pixel pins
    } ispc_pins_t;

    // row strobes routed to the chosen pointer
    typedef struct packed {
        logic selectEn;            // row connected for readout
        logic resetEn;             // row pixels being reset
        logic leftChosen;          // strobes act on left pointer
    } ispc_row_t;

    // column amplifier controls
    typedef struct packed {
        logic hold;                // amplifiers hold their sample
        logic calib;               // column offset calibration on
    } ispc_col_t;

    // output amplifier settings as applied
    typedef struct packed {
        logic       routeExt;      // external input routed
        logic       slowDarkDac;   // stages on offset DAC and output
        logic       unityForced;   // unity gain overrides word
        logic       fastDarkCal;   // fast dark calibration running
        logic [3:0] gain;          // gain word in force
        logic [3:0] blackLevel;    // black offset DAC word
    } ispc_amp_t;

endpackage

// ==== ispc_sync.sv ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ispc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // pin side and clean side
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_reg;  // first stage, read only by second stage

    // plain two-stage chain; nothing taps the first stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= '0;
            dout     <= '0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

// ==== ispc_scan_ptr.sv ====
// one pointer shift chain with sync and end-of-scan flag
`timescale 1ns/1ps
module ispc_scan_ptr #(
    parameter int LENGTH = 1024,
    parameter int PW     = $clog2(LENGTH + 2)
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // synchronised controls
    input  wire logic          initN,
    input  wire logic          step,
    // pointer state
    output logic      [PW-1:0] ptr_reg,
    output logic               scanEndN_reg
);
    localparam logic [PW-1:0] PAST_END = PW'(LENGTH);     // one past last
    localparam logic [PW-1:0] PARKED   = PW'(LENGTH + 1); // idle past end

    logic [PW-1:0] ptr_next;   // pointer after this cycle
    wire           atPark = (ptr_reg == PARKED);

    // sync has priority; a step past the end parks the pointer
    always_comb begin
        ptr_next = ptr_reg;
        if (!initN)
            ptr_next = '0;
        else if (step && !atPark)
            ptr_next = ptr_reg + PW'(1);
    end

    // flag low exactly while the pointer sits one past the last position
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_reg      <= '0;
            scanEndN_reg <= 1'b1;
        end else begin
            ptr_reg      <= ptr_next;
            scanEndN_reg <= (ptr_next != PAST_END);
        end
    end

    a_ptr_init: assert property (@(posedge clk) disable iff (!resetn) // R1 R4 R7
        !initN |=> ptr_reg == '0)
        else $error("pointer not returned to first position");

    a_ptr_step: assert property (@(posedge clk) disable iff (!resetn) // R2 R5 R8
        initN && step && ptr_reg < PAST_END |=> ptr_reg == $past(ptr_reg) + 1)
        else $error("pointer did not advance by one");

    a_ptr_end: assert property (@(posedge clk) disable iff (!resetn) // R3 R6 R9
        initN && step && ptr_reg == PAST_END - 1 |=> !scanEndN_reg
        ##1 (scanEndN_reg || $stable(ptr_reg)))
        else $error("end-of-scan not low after last position");
endmodule

// ==== ispc_top.sv ====
// sensor pin control: pointers, strobes, amplifier settings, pixel word
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ispc_consts.svh"

// What this block does, and what it leaves to the controller (R25, R26)
// R1: right row sync low returns pointer home
// R2: right row clock fall advances one row
// R3: right end-of-scan low after last row
// R4: left row start low sets first row
// R5: left row clock fall advances one row
// R6: left end-of-scan low after last row
// R7: column sync low returns first column
// R8: column clock fall advances one column
// R9: column end-of-scan low after last column
// R10: row select connects addressed row
// R11: row reset clears addressed row pixels
// R12: column amplifiers hold on 1, track 0
// R13: column calibration runs while input high
// R14: selector routes external input on 1
// R15: slow dark-offset switches amplifier stage wiring
// R16: four-bit gain word, bit zero least
// R17: unity gain overrides programmed gain word
// R18: fast dark-offset input triggers calibration
// R19: four-bit black level word, bit three most
// R20: converter samples on clock fall, 10 bits
// R21: invert input flips every pixel bit
// R22: pointer select: 1 left, 0 right
// R23: pixel word lags analog by one pixel
// R24: tristate control floats pins on 1
// R25: controller sets exposure by sync delay
// R26: controller keeps settings stable during conversions
module ispc_top
    import ispc_pkg::*;
#(
    parameter int ROWS = `ISPC_ROWS_DEFAULT,
    parameter int COLS = `ISPC_COLS_DEFAULT,
    parameter int RW   = $clog2(ROWS + 2),
    parameter int CW   = $clog2(COLS + 2)
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     resetn,
    // row pointer pins
    input  wire logic                     rightRowPtrInitN,
    input  wire logic                     rightRowPtrClock,
    input  wire logic                     leftRowPtrInitN,
    input  wire logic                     leftRowPtrClock,
    output logic                          rightRowScanEndN,
    output logic                          leftRowScanEndN,
    // column pointer pins
    input  wire logic                     colPtrInitN,
    input  wire logic                     colPtrClock,
    output logic                          colScanEndN,
    // row and column strobes
    input  wire logic                     rowSelectIn,
    input  wire logic                     rowResetIn,
    input  wire logic                     ptrSelectLeft,
    input  wire logic                     colHoldIn,
    input  wire logic                     colCalibIn,
    // output amplifier pins
    input  wire logic                     ampExtSelectIn,
    input  wire logic                     slowDarkIn,
    input  wire logic [3:0]               ampGainWord,
    input  wire logic                     unityGainIn,
    input  wire logic                     fastDarkIn,
    input  wire logic [3:0]               blackLevelWord,
    // converter pins
    input  wire logic                     adcClock,
    input  wire logic                     bitInvertIn,
    input  wire logic                     outFloatIn,
    input  wire logic [`ISPC_PIXEL_W-1:0] quantizerWord,
    output logic      [`ISPC_PIXEL_W-1:0] pixelWordOut,
    output logic                          pixelWordOe,
    // array-side results
    output logic      [RW-1:0]            rowAddr,
    output ispc_row_t                     rowCtl,
    output logic      [CW-1:0]            colAddr,
    output ispc_col_t                     colCtl,
    output ispc_amp_t                     ampCtl,
    // avalon-mm slave
    input  wire logic [`ISPC_ADDR_W-1:0]  address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    input  wire logic [3:0]               byteenable,
    output logic      [31:0]              readdata,
    output logic                          waitrequest
);
    localparam int PXW = `ISPC_PIXEL_W;

    // ---------------------------------------------------------------
    // pin capture
    // ---------------------------------------------------------------
    ispc_pins_t pinsRaw;      // pins as they arrive
    ispc_pins_t pinsS;        // pins after two flops
    ispc_pins_t pinsPrev_reg; // one cycle older, for edge finding

    // gather every controller-driven pin into one group
    assign pinsRaw = '{
        rightInitN: rightRowPtrInitN, rightClk:   rightRowPtrClock,
        leftInitN:  leftRowPtrInitN,  leftClk:    leftRowPtrClock,
        colInitN:   colPtrInitN,      colClk:     colPtrClock,
        rowSelect:  rowSelectIn,      rowReset:   rowResetIn,
        ptrSelLeft: ptrSelectLeft,    colHold:    colHoldIn,
        colCalib:   colCalibIn,       ampExtSel:  ampExtSelectIn,
        slowDark:   slowDarkIn,       gainWord:   ampGainWord,
        unityGain:  unityGainIn,      fastDark:   fastDarkIn,
        blackWord:  blackLevelWord,   adcClk:     adcClock,
        invertBits: bitInvertIn,      outFloat:   outFloatIn};

    // the pins come from the controller's timing, not ours
    ispc_sync #(
        .W    ($bits(ispc_pins_t))
    ) u_pinSync (
        .clk    (clk),
        .resetn (resetn),
        .din    (pinsRaw),
        .dout   (pinsS)
    );

    // previous sample of the clean pins; feeds falling-edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            pinsPrev_reg <= '0;
        else
            pinsPrev_reg <= pinsS;
    end

    // one-cycle pulses on each falling pin clock
    wire rightFall = pinsPrev_reg.rightClk & ~pinsS.rightClk;
    wire leftFall  = pinsPrev_reg.leftClk  & ~pinsS.leftClk;
    wire colFall   = pinsPrev_reg.colClk   & ~pinsS.colClk;
    wire adcFall   = pinsPrev_reg.adcClk   & ~pinsS.adcClk;

    // ---------------------------------------------------------------
    // pointer chains
    // ---------------------------------------------------------------
    logic [RW-1:0] rightPtr;  // right row pointer position
    logic [RW-1:0] leftPtr;   // left row pointer position

    // right row chain: sync home, step on falling row clock
    ispc_scan_ptr #(
        .LENGTH (ROWS),
        .PW     (RW)
    ) u_rightRow (
        .clk          (clk),
        .resetn       (resetn),
        .initN        (pinsS.rightInitN),       // R1
        .step         (rightFall),              // R2
        .ptr_reg      (rightPtr),
        .scanEndN_reg (rightRowScanEndN)        // R3
    );

    // left row chain, same behaviour on its own pins
    ispc_scan_ptr #(
        .LENGTH (ROWS),
        .PW     (RW)
    ) u_leftRow (
        .clk          (clk),
        .resetn       (resetn),
        .initN        (pinsS.leftInitN),        // R4
        .step         (leftFall),               // R5
        .ptr_reg      (leftPtr),
        .scanEndN_reg (leftRowScanEndN)         // R6
    );

    // column chain; its position selects the pixel on the readout bus
    ispc_scan_ptr #(
        .LENGTH (COLS),
        .PW     (CW)
    ) u_column (
        .clk          (clk),
        .resetn       (resetn),
        .initN        (pinsS.colInitN),         // R7
        .step         (colFall),                // R8
        .ptr_reg      (colAddr),
        .scanEndN_reg (colScanEndN)             // R9
    );

    // ---------------------------------------------------------------
    // row strobe routing
    // ---------------------------------------------------------------
    // exposure is the controller's business: it spaces the two syncs
    // apart; this block only keeps the two chains independent
    wire [RW-1:0] chosenPtr = pinsS.ptrSelLeft ? leftPtr : rightPtr; // R22
    ispc_row_t    rowNext;

    // strobes act on whichever pointer the select pin names
    assign rowNext = '{
        selectEn:   pinsS.rowSelect,                              // R10
        resetEn:    pinsS.rowReset,                               // R11
        leftChosen: pinsS.ptrSelLeft};                            // R22

    // registered so array-side outputs change on one edge together
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rowCtl  <= '0;
            rowAddr <= '0;
        end else begin
            rowCtl  <= rowNext;
            rowAddr <= chosenPtr;
        end
    end

    // ---------------------------------------------------------------
    // column amplifiers and output amplifier
    // ---------------------------------------------------------------
    ispc_amp_t ampNext;  // settings as they take effect

    // gain word bit order is kept: bit zero stays least significant
    assign ampNext = '{
        routeExt:    pinsS.ampExtSel,                             // R14
        slowDarkDac: pinsS.slowDark,                              // R15
        unityForced: pinsS.unityGain,                             // R17
        fastDarkCal: pinsS.fastDark,                              // R18
        gain:        pinsS.gainWord,                              // R16
        blackLevel:  pinsS.blackWord};                            // R19

    // settings follow the pins; a change mid-conversion shows in the pixels,
    // which is why the controller only changes them between conversions
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            colCtl <= '0;
            ampCtl <= '0;
        end else begin
            colCtl.hold  <= pinsS.colHold;                        // R12
            colCtl.calib <= pinsS.colCalib;                       // R13
            ampCtl       <= ampNext;
        end
    end

    // ---------------------------------------------------------------
    // converter pipeline
    // ---------------------------------------------------------------
    logic [PXW-1:0] convHeld_reg;   // sample taken at this edge
    logic [PXW-1:0] pixelHeld_reg;  // result of the previous pixel
    logic           ctrlFloat_reg;  // software forces pins to float

    // each falling conversion clock samples and shifts one stage, so
    // the word on the pins belongs to the column selected before
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            convHeld_reg  <= '0;
            pixelHeld_reg <= '0;
        end else if (adcFall) begin
            convHeld_reg  <= quantizerWord;                       // R20
            pixelHeld_reg <= convHeld_reg;                        // R23
        end
    end

    // inversion and pin drive applied on the way out
    wire [PXW-1:0] pixelNext = pixelHeld_reg ^ {PXW{pinsS.invertBits}};
    wire           driveNext = ~(pinsS.outFloat | ctrlFloat_reg);

    // outputs from flops; float only drops the enable, data keeps updating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pixelWordOut <= '0;
            pixelWordOe  <= 1'b0;
        end else begin
            pixelWordOut <= pixelNext;                            // R21
            pixelWordOe  <= driveNext;                            // R24
        end
    end

    // ---------------------------------------------------------------
    // avalon-mm register slave
    // ---------------------------------------------------------------
    logic busAck_reg;  // high in the cycle the answer stands
    wire  busReq   = read | write;
    wire  isCtrl   = (address == `ISPC_OFS_CTRL);
    wire  ctrlWrEn = write & busAck_reg & isCtrl & byteenable[0];

    // one wait cycle per access; readdata loads while waitrequest is high
    assign waitrequest = busReq & ~busAck_reg;

    // read mux; unmapped offsets read as zero
    logic [31:0] readNext;
    always_comb begin
        case (address)
            `ISPC_OFS_ROWPTR:  readNext = {16'(leftPtr), 16'(rightPtr)};
            `ISPC_OFS_COLSTAT: readNext = {13'h0000, leftRowScanEndN,
                                           rightRowScanEndN, colScanEndN,
                                           16'(colAddr)};
            `ISPC_OFS_CTRL:    readNext = {31'h00000000, ctrlFloat_reg};
            `ISPC_OFS_PIXEL:   readNext = {22'h000000, pixelHeld_reg};
            default:           readNext = 32'h00000000;
        endcase
    end

    // ack toggles so no access is answered twice
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busAck_reg <= 1'b0;
            readdata   <= 32'h00000000;
        end else begin
            busAck_reg <= busReq & ~busAck_reg;
            if (read & ~busAck_reg)
                readdata <= readNext;
        end
    end

    // control register; write lands on the edge waitrequest is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            ctrlFloat_reg <= `ISPC_CTRL_RESET;
        else if (ctrlWrEn)
            ctrlFloat_reg <= writedata[`ISPC_CTRL_FLOAT_BIT];
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence adcEdgeS;
        adcFall;
    endsequence
    sequence resultShiftS;
        ##1 pixelHeld_reg == $past(convHeld_reg);
    endsequence

    a_row_route: assert property ( // R22
        pinsS.ptrSelLeft |=> rowAddr == $past(leftPtr) && rowCtl.leftChosen)
        else $error("row strobes not routed to left pointer");

    a_select_reset: assert property ( // R10 R11
        pinsS.rowSelect && pinsS.rowReset |=> rowCtl.selectEn
        && rowCtl.resetEn)
        else $error("row strobes not passed on");

    a_pixel_lag: assert property (adcEdgeS |-> resultShiftS) // R23
        else $error("pixel word not one conversion behind");

    a_pixel_invert: assert property ( // R21
        pinsS.invertBits && !adcFall |=> pixelWordOut == ~pixelHeld_reg)
        else $error("pixel word not inverted");

    a_pins_float: assert property ( // R24
        pinsS.outFloat |=> !pixelWordOe)
        else $error("pixel pins driven while float requested");

    a_unity_gain: assert property ( // R17
        pinsS.unityGain |=> ampCtl.unityForced
        && ampCtl.gain == $past(pinsS.gainWord))
        else $error("unity gain not applied");

    a_col_hold: assert property ( // R12
        $changed(pinsS.colHold) |=> colCtl.hold == $past(pinsS.colHold))
        else $error("column hold not following pin");

    a_bus_answer: assert property (
        busReq && !busAck_reg |=> busAck_reg && !waitrequest)
        else $error("bus access not answered in one wait cycle");
endmodule

// ==== ispc_cam_ctrl.sv ====
// camera controller model that drives the sensor pins
`timescale 1ns/1ps
module ispc_cam_ctrl
    import ispc_pkg::*;
(
    // clock
    input  wire logic clk,
    // pins toward the sensor
    output ispc_pins_t pins
);
    // syncs idle high, clocks idle low
    initial pins = '{rightInitN: 1'h1, leftInitN: 1'h1,
                     colInitN: 1'h1, default: '0};

    // drive clock or sync of k (0 col, 1 right, 2 left, 3 adc);
    // 3 clk per phase so the 2-flop synchroniser never misses one
    task automatic drv(input int k, input bit s, input logic v);
        @(posedge clk);
        case (k)
            0: if (s) pins.colInitN <= v; else pins.colClk <= v;
            1: if (s) pins.rightInitN <= v; else pins.rightClk <= v;
            2: if (s) pins.leftInitN <= v; else pins.leftClk <= v;
            default: pins.adcClk <= v;
        endcase
        repeat (2) @(posedge clk);
    endtask

    // one clock pulse; its falling edge does the work
    task automatic pulse(input int k);
        drv(k, 1'b0, 1'h1);
        drv(k, 1'b0, 1'h0);
    endtask

    // sync pulse per pointer; spacing between them sets exposure
    task automatic sync(input int k);
        drv(k, 1'b1, 1'h0);
        drv(k, 1'b1, 1'h1);
    endtask

    // levels change only between pulses, never mid-conversion
    task automatic setup(input ispc_pins_t v);
        @(posedge clk);
        pins <= {pins[25:20], v[19:3], pins.adcClk, v[1:0]};
    endtask
endmodule

// ==== ispc_tb_top.sv ====
// self-checking bench for the sensor pin control block
`timescale 1ns/1ps
`include "ispc_consts.svh"
module ispc_tb_top
    import ispc_pkg::*;
;
    localparam int LEN = 8;   // short chains keep the run brief
    logic clk = 1'h0, resetn = 1'h0, read = 1'h0, write = 1'h0;
    logic rightRowScanEndN, leftRowScanEndN, colScanEndN;
    logic pixelWordOe, waitrequest;
    logic [`ISPC_PIXEL_W-1:0] quantizerWord = 10'h000, pixelWordOut;
    logic [3:0]  rowAddr, colAddr, address = 4'h0, byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata, rdCap = 32'h0, expNote;
    ispc_row_t   rowCtl;
    ispc_col_t   colCtl;
    ispc_amp_t   ampCtl;
    ispc_pins_t  p;
    logic [31:0] exq [$];    // expected results, oldest first
    logic [31:0] obs [8];    // watched outputs by selector
    int n_mismatch = 0, checked = 0, sel = 0, seed = 32'h71fab7f6;
    bit look = 1'b0;

    always #4 clk = ~clk;

    ispc_cam_ctrl ispc_cam_ctrl_inst (.clk(clk), .pins(p));
    ispc_top #(.ROWS(LEN), .COLS(LEN)) ispc_top_inst (.*,
        .rightRowPtrInitN(p.rightInitN), .rightRowPtrClock(p.rightClk),
        .leftRowPtrInitN(p.leftInitN), .leftRowPtrClock(p.leftClk),
        .colPtrInitN(p.colInitN), .colPtrClock(p.colClk),
        .rowSelectIn(p.rowSelect), .rowResetIn(p.rowReset),
        .ptrSelectLeft(p.ptrSelLeft), .colHoldIn(p.colHold),
        .colCalibIn(p.colCalib), .ampExtSelectIn(p.ampExtSel),
        .slowDarkIn(p.slowDark), .ampGainWord(p.gainWord),
        .unityGainIn(p.unityGain), .fastDarkIn(p.fastDark),
        .blackLevelWord(p.blackWord), .adcClock(p.adcClk),
        .bitInvertIn(p.invertBits), .outFloatIn(p.outFloat));

    // gain field is masked while unity gain overrides it
    assign obs[0] = 32'(colAddr);
    assign obs[1] = 32'(colScanEndN);
    assign obs[2] = 32'(rowAddr);
    assign obs[3] = {30'h0, rightRowScanEndN, leftRowScanEndN};
    assign obs[4] = {15'h0, rowCtl, colCtl, ampCtl[11:8],
                     ampCtl.unityForced ? 4'h0 : ampCtl.gain, ampCtl[3:0]};
    assign obs[5] = 32'(pixelWordOut);
    assign obs[6] = 32'(pixelWordOe);
    assign obs[7] = rdCap;

    // watcher: takes the oldest note whenever a result is flagged
    always @(posedge clk) begin
        if (look) begin
            expNote = exq.pop_front();
            checked++;
            if (obs[sel] !== expNote) begin
                n_mismatch++;
                $display("BAD t=%0t got=%h exp=%h", $time, obs[sel], expNote);
            end
        end
    end

    // note an expected value and flag the result for the watcher
    task automatic note(input int s, input logic [31:0] e);
        @(posedge clk);
        exq.push_back(e);
        sel  <= s;
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        writedata <= d;
        read      <= ~wr;
        write     <= wr;
        // waitrequest and readdata are looked at on the rising edge,
        // before that edge's updates land, then the request is dropped
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'h0 && n < 100);
        rdCap = readdata;
        if (n >= 100) n_mismatch++;
        read  <= 1'h0;
        write <= 1'h0;
    endtask

    // pointer k against address a and its end flag f
    task automatic ptr_chk(input int k, input int a, input logic f);
        note(k ? 2 : 0, 32'(a));
        note(k ? 3 : 1, k == 0 ? 32'(f) :
             k == 1 ? {30'h0, f, 1'h1} : {30'h0, 1'h1, f});
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: the run needs about 650 cycles, allow far more
    initial begin
        #(20000 * 8);
        n_mismatch++;
        finish_test();
    end

    initial begin
        ispc_pins_t v;
        logic [9:0] q, lastQ;
        lastQ = 10'h000;
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        ptr_chk(1, 0, 1'h1);
        // pointers: col, right, left; walk past the end and park
        for (int k = 0; k < 3; k++) begin
            v = '0;
            v.ptrSelLeft = (k == 2);
            ispc_cam_ctrl_inst.setup(v);
            ispc_cam_ctrl_inst.sync(k);
            for (int i = 0; i <= LEN + 2; i++) begin
                repeat (2) @(posedge clk);
                ptr_chk(k, i > LEN ? LEN + 1 : i, i != LEN);
                ispc_cam_ctrl_inst.pulse(k);
            end
            ispc_cam_ctrl_inst.sync(k);
            ptr_chk(k, 0, 1'h1);
        end
        // random strobe and amplifier levels
        for (int t = 0; t < 8; t++) begin
            v = ispc_pins_t'(26'($random(seed)));
            ispc_cam_ctrl_inst.setup(v);
            repeat (3) @(posedge clk);
            note(4, {15'h0, v[19:13], v.unityGain, v.fastDark,
                 v.unityGain ? 4'h0 : v.gainWord, v.blackWord});
        end
        // conversions: result lags one sample, inversion, float
        for (int t = 0; t < 6; t++) begin
            v = ispc_pins_t'(26'($random(seed)));
            q = 10'($random(seed));
            ispc_cam_ctrl_inst.setup(v);
            quantizerWord <= q;
            ispc_cam_ctrl_inst.pulse(3);
            repeat (3) @(posedge clk);
            if (t > 0) note(5, 32'(lastQ ^ {10{v.invertBits}}));
            note(6, 32'(!v.outFloat));
            bus(1'h0, 4'hC, 32'h0);
            if (t > 0) note(7, 32'(lastQ));
            lastQ = q;
        end
        // control register, forced float, unmapped offset
        bus(1'h0, 4'h8, 32'h0);
        note(7, 32'h0);
        bus(1'h1, 4'h8, 32'h1);
        bus(1'h0, 4'h8, 32'h0);
        note(7, 32'h1);
        note(6, 32'h0);
        bus(1'h1, 4'h8, 32'h0);
        bus(1'h1, 4'h2, 32'hFFFFFFFF);
        bus(1'h0, 4'h2, 32'h0);
        note(7, 32'h0);
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule
